// File: verilog/stmsq_pkg.sv
package stmsq_pkg;

  // register byte offsets on the control bus
  localparam logic [7:0] OFS_SQ_RX      = 8'h00; // sq_receive_first_reg
  localparam logic [7:0] OFS_SQ_TX      = 8'h04; // sq_transmit_first_reg
  localparam logic [7:0] OFS_AUX_CFG    = 8'h08; // aux_config_reg
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h0C; // sticky events, write one to clear
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h10; // event enables

  // field positions
  localparam int SQ_BITS_W      = 4;   // four S1 or Q bits per multiframe
  localparam int POS_LOCK       = 4;   // multiframe_lock_flag in receive reg
  localparam int POS_MULTIFRAME_ENABLE       = 4;   // multiframe_enable in transmit reg
  localparam int POS_SYNC_SEL   = 0;   // aux_pin_sync_select
  localparam int POS_GPIO_OUT   = 1;   // general purpose output value
  localparam int POS_GPIO_OE    = 2;   // general purpose output enable
  localparam int POS_MODE_LO    = 4;   // two-bit operating mode
  localparam int POS_GPIO_IN    = 8;   // pin level, read only
  localparam int POS_IRQ_TICK   = 0;   // multiframe_tick_irq
  localparam int POS_IRQ_CHG    = 1;   // sq_data_changed_irq

  // reset values
  localparam logic [7:0] RST_SQ_TX    = 8'h00;
  localparam logic [7:0] RST_AUX_CFG  = 8'h00;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;

  // multiframe geometry
  localparam logic [4:0] FRAME_FIRST  = 5'h01;
  localparam logic [4:0] FRAME_LAST   = 5'h14; // frame 20
  localparam logic [4:0] FRAME_PRELAST = 5'h13; // frame 19
  localparam logic [4:0] SUBFRAME_LEN = 5'h05; // slot every 5th frame

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // operating modes
  typedef enum logic [1:0] {
    MODE_TE  = 2'b00,  // terminal
    MODE_NT  = 2'b01,  // network termination
    MODE_LTS = 2'b10,  // line_term_s_mode
    MODE_LTT = 2'b11   // line_term_t_mode
  } stmsq_mode_e;

  // multiframe lock tracker states
  typedef enum logic [1:0] {
    LK_HUNT  = 2'b00,
    LK_CHECK = 2'b01,
    LK_LOCK  = 2'b10
  } stmsq_lock_e;

endpackage : stmsq_pkg

// File: verilog/stmsq_channel.sv
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// Notes on behaviour
// RQ1: upstream Q bits ride in auxiliary framing position
// RQ2: only first S sub-channel is handled
// RQ3: host reaches S/Q bits through dedicated registers
// RQ4: locked terminal sends Q in frames 1,6,11,16
// RQ5: unlocked terminal mirrors received FA bit upstream
// RQ6: lock after two complete good multiframes
// RQ7: lock lost after two consecutive errored multiframes
// RQ8: lock state readable in first receive register
// RQ9: enable flag switches multiframe synchronization
// RQ10: network side multiframes only when enabled
// RQ11: network FA ones 1,6,11,16, M in 1
// RQ12: interrupt once per multiframe
// RQ13: interrupt when received S or Q changes
// RQ14: host finishes access within one multiframe
// RQ15: select flag turns shared pin into sync
// RQ16: host enables multiframing before using sync input
// RQ17: sync input sampled at framing bit start
// RQ18: sync high holds counter at frame 20
// RQ19: sync low restarts counting at frame 1
// RQ20: terminal modes drive received M on pin
// RQ21: outside logic samples M at strobe falling edge
// RQ22: M one marks first frame of multiframe
// RQ23: logic zero gives pulses, logic one quiet
// RQ24: network counter free-runs when pin unselected
module stmsq_channel #(
  parameter int ADDR_W = 8  // byte address width of the register window
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // axi4-lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // axi4-lite read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // line frame timing and received maintenance bits
  input  wire logic              frame_strobe,
  input  wire logic              rx_fa_bit,
  input  wire logic              rx_m_bit,
  input  wire logic              rx_s_bit,
  // transmitted maintenance bits, logic values
  output logic                   tx_fa_bit,
  output logic                   tx_m_bit,
  output logic                   tx_s_bit,
  // shared_aux_pin as three signals
  input  wire logic              shared_aux_pin_in,
  output logic                   shared_aux_pin_out,
  output logic                   shared_aux_pin_oe,
  // combined event output
  output logic                   sq_irq
);

  localparam int SQ_BITS_W = stmsq_pkg::SQ_BITS_W; // local copy, nothing is imported
  // ---------------- register state ----------------
  logic [SQ_BITS_W-1:0] rx_sq_ff;      // received_sq_bits
  logic [SQ_BITS_W-1:0] tx_sq_ff;      // transmit_sq_bits
  logic                 multiframe_enable_ff;       // multiframe_enable
  logic [7:0]           cfg_ff;        // aux_config_reg
  logic [1:0]           irq_stat_ff;   // sticky tick / changed
  logic [1:0]           irq_mask_ff;   // event enables
  // ---------------- multiframe state ----------------
  logic [4:0]           frame_ff;      // current frame number 1..20
  logic [SQ_BITS_W-1:0] cap_ff;        // bits gathered this multiframe
  logic [SQ_BITS_W-1:0] shadow_ff;     // bits being transmitted
  stmsq_pkg::stmsq_lock_e lock_st_ff;  // lock tracker
  logic                 good_ff;       // one good multiframe seen
  logic                 bad_ff;        // one errored multiframe seen
  logic                 mf_err_ff;     // error inside current multiframe
  // ---------------- output flops ----------------
  logic tx_fa_ff, tx_m_ff, tx_s_ff, pin_out_ff, pin_oe_ff, irq_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic        aw_have_ff, w_have_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0]  wbyte_ff;
  logic        wlane_ff;
  // next frame after n, wrapping 20 back to 1
  function automatic logic [4:0] frame_inc(input logic [4:0] n);
    frame_inc = (n == stmsq_pkg::FRAME_LAST) ? stmsq_pkg::FRAME_FIRST : 5'(n + 5'h01);
  endfunction : frame_inc
  // frames 1, 6, 11 and 16 carry FA ones, Q and S1
  function automatic logic is_slot(input logic [4:0] n);
    is_slot = (n != 5'h00) && (n <= 5'h10) &&
              ((5'(n - 5'h01) % stmsq_pkg::SUBFRAME_LEN) == 5'h00);
  endfunction : is_slot
  // which of the four slots a frame is
  function automatic logic [1:0] slot_idx(input logic [4:0] n);
    slot_idx = 2'(5'(n - 5'h01) / stmsq_pkg::SUBFRAME_LEN);
  endfunction : slot_idx
  // register byte offset match on the word address
  function automatic logic ofs_hit(input logic [ADDR_W-1:0] a, input logic [7:0] o);
    ofs_hit = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
  endfunction : ofs_hit
  // ---------------- decode of configuration ----------------
  wire [1:0] mode_w      = cfg_ff[stmsq_pkg::POS_MODE_LO +: 2];
  wire       nt_side     = (mode_w == stmsq_pkg::MODE_NT) || (mode_w == stmsq_pkg::MODE_LTS);
  wire       sync_sel    = cfg_ff[stmsq_pkg::POS_SYNC_SEL];
  wire       locked      = (lock_st_ff == stmsq_pkg::LK_LOCK);
  // sync input only acts while multiframing runs
  wire       sync_hold   = sync_sel && shared_aux_pin_in;           // RQ15 RQ17

  // ---------------- next frame number ----------------
  // network: idle at 20 until enabled, hold on sync, else free-run
  wire [4:0] nt_next = !multiframe_enable_ff  ? stmsq_pkg::FRAME_LAST :          // RQ10
                       sync_hold ? stmsq_pkg::FRAME_LAST :          // RQ16 RQ18
                       frame_inc(frame_ff);                         // RQ19 RQ24
  // terminal: hunting aligns on M one with FA one
  wire       te_align = (lock_st_ff == stmsq_pkg::LK_HUNT) && rx_m_bit && rx_fa_bit; // RQ22
  wire [4:0] te_next  = te_align ? stmsq_pkg::FRAME_FIRST : frame_inc(frame_ff);
  wire [4:0] nxt_frame = nt_side ? nt_next : te_next;

  // received pattern against the expected one for this frame
  wire exp_fa   = is_slot(nxt_frame);
  wire exp_m    = (nxt_frame == stmsq_pkg::FRAME_FIRST);
  wire mismatch = (rx_fa_bit != exp_fa) || (rx_m_bit != exp_m);     // RQ6 RQ7
  wire mf_done  = frame_strobe && (nxt_frame == stmsq_pkg::FRAME_LAST) &&
                  (frame_ff == stmsq_pkg::FRAME_PRELAST);
  wire mf_err   = mf_err_ff || mismatch;
  // a multiframe counts for the host only when running or locked
  wire mf_event = mf_done && (nt_side ? multiframe_enable_ff : locked);          // RQ12
  // gathered bits as registered, without the slot of this very frame
  wire [SQ_BITS_W-1:0] cap_now = cap_ff;
  wire chg_event = mf_event && (cap_now != rx_sq_ff);               // RQ13

  // ---------------- transmitted bits ----------------
  wire slot_bit  = shadow_ff[slot_idx(nxt_frame)];
  // logic zero here means a line pulse, logic one a quiet line
  wire nt_fa  = is_slot(nxt_frame);                                 // RQ11 RQ23
  wire nt_m   = (nxt_frame == stmsq_pkg::FRAME_FIRST);              // RQ11 RQ22
  wire nt_s   = is_slot(nxt_frame) && slot_bit;                     // RQ2 RQ11
  wire te_fa  = locked ? (is_slot(nxt_frame) && slot_bit)           // RQ1 RQ4
                       : rx_fa_bit;                                 // RQ5

  // ---------------- bus decode ----------------
  wire aw_hs   = s_axi_awvalid && awready_ff;
  wire w_hs    = s_axi_wvalid && wready_ff;
  wire b_hs    = bvalid_ff && s_axi_bready;
  wire ar_hs   = s_axi_arvalid && arready_ff;
  wire r_hs    = rvalid_ff && s_axi_rready;
  wire aw_now  = aw_have_ff || aw_hs;
  wire w_now   = w_have_ff || w_hs;
  wire [ADDR_W-1:0] wa = aw_have_ff ? awaddr_ff : s_axi_awaddr;
  wire [7:0]  wb   = w_have_ff ? wbyte_ff : s_axi_wdata[7:0];
  wire        wl   = w_have_ff ? wlane_ff : s_axi_wstrb[0];
  wire do_write    = aw_now && w_now && !bvalid_ff;
  wire wr_en       = do_write && wl;                                // low lane holds all fields
  wire wr_rx       = ofs_hit(wa, stmsq_pkg::OFS_SQ_RX);
  wire wr_tx       = wr_en && ofs_hit(wa, stmsq_pkg::OFS_SQ_TX);    // RQ3 RQ9
  wire wr_cfg      = wr_en && ofs_hit(wa, stmsq_pkg::OFS_AUX_CFG);
  wire wr_stat     = wr_en && ofs_hit(wa, stmsq_pkg::OFS_IRQ_STAT);
  wire wr_mask     = wr_en && ofs_hit(wa, stmsq_pkg::OFS_IRQ_MASK);
  wire w_mapped    = wr_rx || ofs_hit(wa, stmsq_pkg::OFS_SQ_TX) ||
                     ofs_hit(wa, stmsq_pkg::OFS_AUX_CFG) ||
                     ofs_hit(wa, stmsq_pkg::OFS_IRQ_STAT) ||
                     ofs_hit(wa, stmsq_pkg::OFS_IRQ_MASK);
  wire [ADDR_W-1:0] ra = s_axi_araddr;
  wire r_rx   = ofs_hit(ra, stmsq_pkg::OFS_SQ_RX);
  wire r_tx   = ofs_hit(ra, stmsq_pkg::OFS_SQ_TX);
  wire r_cfg  = ofs_hit(ra, stmsq_pkg::OFS_AUX_CFG);
  wire r_st   = ofs_hit(ra, stmsq_pkg::OFS_IRQ_STAT);
  wire r_mk   = ofs_hit(ra, stmsq_pkg::OFS_IRQ_MASK);
  // read data mux, unused bits zero
  wire [31:0] rd_mux =
    r_rx  ? 32'({locked, rx_sq_ff}) :                               // RQ3 RQ8
    r_tx  ? 32'({multiframe_enable_ff, tx_sq_ff}) :
    r_cfg ? 32'({shared_aux_pin_in, cfg_ff}) :
    r_st  ? 32'(irq_stat_ff) :
    r_mk  ? 32'(irq_mask_ff) : 32'h0000_0000;
  wire r_mapped = r_rx || r_tx || r_cfg || r_st || r_mk;

  // ---------------- bus slave ----------------
  // each channel accepted once, response after both halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wbyte_ff   <= 8'h00;
      wlane_ff   <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= stmsq_pkg::RESP_OKAY;
    end else begin
      aw_have_ff <= aw_now && !b_hs;
      w_have_ff  <= w_now && !b_hs;
      if (aw_hs) awaddr_ff <= s_axi_awaddr;
      if (w_hs) begin
        wbyte_ff <= s_axi_wdata[7:0];
        wlane_ff <= s_axi_wstrb[0];
      end
      // ready again only after the response is gone
      awready_ff <= !(aw_now && !b_hs) && !do_write && !(bvalid_ff && !b_hs);
      wready_ff  <= !(w_now && !b_hs) && !do_write && !(bvalid_ff && !b_hs);
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= w_mapped ? stmsq_pkg::RESP_OKAY : stmsq_pkg::RESP_SLVERR;
      end else if (b_hs) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= stmsq_pkg::RESP_OKAY;
    end else begin
      arready_ff <= !ar_hs && !(rvalid_ff && !r_hs);
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_mux;
        rresp_ff  <= r_mapped ? stmsq_pkg::RESP_OKAY : stmsq_pkg::RESP_SLVERR;
      end else if (r_hs) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ---------------- software registers ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sq_ff    <= stmsq_pkg::RST_SQ_TX[SQ_BITS_W-1:0];
      multiframe_enable_ff     <= stmsq_pkg::RST_SQ_TX[stmsq_pkg::POS_MULTIFRAME_ENABLE];
      cfg_ff      <= stmsq_pkg::RST_AUX_CFG;
      irq_mask_ff <= stmsq_pkg::RST_IRQ_MASK;
      irq_stat_ff <= 2'h0;
    end else begin
      if (wr_tx) begin
        tx_sq_ff <= wb[SQ_BITS_W-1:0];
        multiframe_enable_ff  <= wb[stmsq_pkg::POS_MULTIFRAME_ENABLE];                        // RQ9
      end
      if (wr_cfg) cfg_ff <= {2'h0, wb[5:4], 1'b0, wb[2:0]};
      if (wr_mask) irq_mask_ff <= wb[1:0];
      // write one clears, a new event in the same cycle wins
      irq_stat_ff <= (irq_stat_ff & ~(wr_stat ? wb[1:0] : 2'h0)) |
                     {chg_event, mf_event};                         // RQ12 RQ13
    end
  end

  // ---------------- multiframe counter and bit capture ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_ff  <= stmsq_pkg::FRAME_LAST;
      cap_ff    <= '0;
      shadow_ff <= '0;
      rx_sq_ff  <= '0;
    end else if (frame_strobe) begin
      frame_ff <= nxt_frame;
      // Q from the terminal or S1 from the network, one per slot
      if (is_slot(nxt_frame)) cap_ff[slot_idx(nxt_frame)] <= nt_side ? rx_fa_bit : rx_s_bit;
      // freeze transmit bits for the coming multiframe
      if (nxt_frame == stmsq_pkg::FRAME_LAST) shadow_ff <= tx_sq_ff; // RQ14
      if (mf_event) rx_sq_ff <= cap_now;                           // RQ3
    end
  end

  // ---------------- lock tracker, terminal side ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_st_ff <= stmsq_pkg::LK_HUNT;
      good_ff    <= 1'b0;
      bad_ff     <= 1'b0;
      mf_err_ff  <= 1'b0;
    end else if (nt_side || !multiframe_enable_ff) begin
      lock_st_ff <= stmsq_pkg::LK_HUNT;                             // RQ9
      good_ff    <= 1'b0;
      bad_ff     <= 1'b0;
      mf_err_ff  <= 1'b0;
    end else if (frame_strobe) begin
      unique case (lock_st_ff)
        stmsq_pkg::LK_HUNT: begin
          // candidate frame 1 found
          if (te_align) lock_st_ff <= stmsq_pkg::LK_CHECK;
          good_ff   <= 1'b0;
          bad_ff    <= 1'b0;
          mf_err_ff <= 1'b0;
        end
        stmsq_pkg::LK_CHECK: begin
          mf_err_ff <= mf_done ? 1'b0 : mf_err;
          if (mf_done) begin
            if (mf_err) lock_st_ff <= stmsq_pkg::LK_HUNT;
            else if (good_ff) lock_st_ff <= stmsq_pkg::LK_LOCK;      // RQ6
            good_ff <= !mf_err;
          end
        end
        stmsq_pkg::LK_LOCK: begin
          mf_err_ff <= mf_done ? 1'b0 : mf_err;
          if (mf_done) begin
            // only a second errored multiframe in a row drops lock
            if (mf_err && bad_ff) lock_st_ff <= stmsq_pkg::LK_HUNT; // RQ7
            bad_ff <= mf_err;
          end
        end
        default: lock_st_ff <= stmsq_pkg::LK_HUNT;
      endcase
    end
  end

  // ---------------- line bits, pin and event output ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_fa_ff   <= 1'b0;
      tx_m_ff    <= 1'b0;
      tx_s_ff    <= 1'b0;
      pin_out_ff <= 1'b0;
      pin_oe_ff  <= 1'b0;
      irq_ff     <= 1'b0;
    end else begin
      if (frame_strobe) begin
        tx_fa_ff <= nt_side ? nt_fa : te_fa;
        tx_m_ff  <= nt_side && nt_m;
        tx_s_ff  <= nt_side && nt_s;
      end
      // pin: gpio, sync input (network) or M output (terminal)
      if (!sync_sel) begin
        pin_out_ff <= cfg_ff[stmsq_pkg::POS_GPIO_OUT];
        pin_oe_ff  <= cfg_ff[stmsq_pkg::POS_GPIO_OE];
      end else begin
        pin_oe_ff <= !nt_side;                                      // RQ15
        if (frame_strobe) pin_out_ff <= rx_m_bit;                   // RQ20 RQ21
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign s_axi_awready      = awready_ff;
  assign s_axi_wready       = wready_ff;
  assign s_axi_bvalid       = bvalid_ff;
  assign s_axi_bresp        = bresp_ff;
  assign s_axi_arready      = arready_ff;
  assign s_axi_rvalid       = rvalid_ff;
  assign s_axi_rdata        = rdata_ff;
  assign s_axi_rresp        = rresp_ff;
  assign tx_fa_bit          = tx_fa_ff;
  assign tx_m_bit           = tx_m_ff;
  assign tx_s_bit           = tx_s_ff;
  assign shared_aux_pin_out = pin_out_ff;
  assign shared_aux_pin_oe  = pin_oe_ff;
  assign sq_irq             = irq_ff;
  // ---------------- assertions ----------------
  AST_NT_DISABLED: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
    nt_side && !multiframe_enable_ff && frame_strobe |=> !tx_fa_bit && !tx_m_bit && !tx_s_bit)
    else $error("network side sent multiframe bits while disabled");
  AST_SYNC_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // RQ18
    nt_side && multiframe_enable_ff && sync_sel && shared_aux_pin_in && frame_strobe |=>
      frame_ff == 5'h14 && !tx_fa_bit && !tx_m_bit && !tx_s_bit)
    else $error("sync input high did not hold frame 20");
  AST_SYNC_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ19
    nt_side && multiframe_enable_ff && frame_strobe && !(sync_sel && shared_aux_pin_in) &&
      frame_ff == 5'h14 |=> frame_ff == 5'h01 && tx_fa_bit && tx_m_bit)
    else $error("release of sync input did not start frame 1");
  AST_M_FIRST_ONLY: assert property (@(posedge aclk) disable iff (!aresetn) // RQ22
    tx_m_bit |-> frame_ff == 5'h01 && tx_fa_bit)
    else $error("M sent outside frame 1");
  AST_TE_MIRROR: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
    !nt_side && !locked && frame_strobe |=> tx_fa_bit == $past(rx_fa_bit))
    else $error("unlocked terminal did not mirror FA");
  AST_TE_Q_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
    !nt_side && locked && frame_strobe && !is_slot(nxt_frame) |=> !tx_fa_bit)
    else $error("locked terminal sent FA one outside a Q slot");
  AST_LOCK_ENTRY: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
    $rose(locked) |-> $past(lock_st_ff) == stmsq_pkg::LK_CHECK && $past(good_ff) &&
      $past(mf_done))
    else $error("lock declared without two good multiframes");
  AST_M_PIN_OUT: assert property (@(posedge aclk) disable iff (!aresetn) // RQ20
    !nt_side && sync_sel && frame_strobe |=> shared_aux_pin_oe &&
      shared_aux_pin_out == $past(rx_m_bit))
    else $error("received M not driven on sync pin");
  // irq flop follows the status and mask of the cycle before it
  AST_TICK_SET: assert property (@(posedge aclk) disable iff (!aresetn) // RQ12
    mf_event |=> irq_stat_ff[stmsq_pkg::POS_IRQ_TICK] ##1
      (sq_irq == $past(irq_mask_ff[stmsq_pkg::POS_IRQ_TICK]) ||
       $past(irq_stat_ff[stmsq_pkg::POS_IRQ_CHG])))
    else $error("multiframe event not flagged");
endmodule : stmsq_channel

// File: verif/stmsq_far_end.sv
`timescale 1ns/100ps
// far end: strobe every 8 cycles with downstream maintenance bits
module stmsq_far_end (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // scenario controls
  input  wire logic       err_mf,
  input  wire logic [3:0] s_pat,
  // received line bits
  output logic            frame_strobe,
  output logic            rx_fa_bit,
  output logic            rx_m_bit,
  output logic            rx_s_bit,
  output logic [4:0]      frame_no
);
  logic [2:0] cyc_ff;    // cycle inside a line frame
  logic [4:0] nxt_frame; // frame about to start
  logic [4:0] slot_k;    // slot index of that frame
  logic       slot;      // frame is a slot frame
  assign nxt_frame = (frame_no == 5'h14) ? 5'h01 : frame_no + 5'h01;
  assign slot_k    = (nxt_frame - 5'h01) / 5'h05;
  assign slot      = ((nxt_frame - 5'h01) % 5'h05) == 5'h00;
  // bits valid only with the strobe; inverted after so stale values never pass
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_ff <= 3'h0;
      frame_no <= 5'h14;
      frame_strobe <= 1'b0;
      {rx_fa_bit, rx_m_bit, rx_s_bit} <= 3'h0;
    end else begin
      cyc_ff <= cyc_ff + 3'h1;
      frame_strobe <= (cyc_ff == 3'h6);
      if (cyc_ff == 3'h6) begin
        frame_no <= nxt_frame;
        rx_fa_bit <= slot ^ (err_mf && nxt_frame == 5'h02);
        rx_m_bit <= (nxt_frame == 5'h01);
        rx_s_bit <= slot ? s_pat[slot_k[1:0]] : 1'b1;
      end else if (cyc_ff == 3'h7) begin
        {rx_fa_bit, rx_m_bit, rx_s_bit} <= ~{rx_fa_bit, rx_m_bit, rx_s_bit};
      end
    end
  end
endmodule : stmsq_far_end

// File: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  // short names for offsets and responses
  localparam logic [7:0] A_RX = stmsq_pkg::OFS_SQ_RX;
  localparam logic [7:0] A_TX = stmsq_pkg::OFS_SQ_TX;
  localparam logic [7:0] A_CF = stmsq_pkg::OFS_AUX_CFG;
  localparam logic [7:0] A_ST = stmsq_pkg::OFS_IRQ_STAT;
  localparam logic [7:0] A_MK = stmsq_pkg::OFS_IRQ_MASK;
  localparam logic [1:0] OK = stmsq_pkg::RESP_OKAY;
  localparam logic [1:0] SE = stmsq_pkg::RESP_SLVERR;
  // bench-driven inputs
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, pin_in = 1'b0, err_mf = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0, s_pat = 4'h5, qx = 4'hB;
  // observed signals
  logic awready, wready, bvalid, arready, rvalid, tx_fa, tx_m, tx_s, pin_out, pin_oe, irq;
  logic strobe, rx_fa, rx_m, rx_s, fa, m;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] fno, f, fr;
  int n_mismatch = 0, n_checks = 0;
  always #25 aclk = ~aclk;
  stmsq_channel u_stmsq_channel (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .frame_strobe(strobe), .rx_fa_bit(rx_fa), .rx_m_bit(rx_m), .rx_s_bit(rx_s), .tx_fa_bit(tx_fa),
    .tx_m_bit(tx_m), .tx_s_bit(tx_s), .shared_aux_pin_in(pin_in), .shared_aux_pin_out(pin_out),
    .shared_aux_pin_oe(pin_oe), .sq_irq(irq));
  stmsq_far_end u_stmsq_far_end (.aclk(aclk), .aresetn(aresetn), .err_mf(err_mf), .s_pat(s_pat),
    .frame_strobe(strobe), .rx_fa_bit(rx_fa), .rx_m_bit(rx_m), .rx_s_bit(rx_s), .frame_no(fno));
  // one comparison, mismatch reported at once
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    @(posedge aclk);
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready && !aw_done) begin awvalid <= 1'b0; aw_done = 1'b1; end
      if (wready && !w_done) begin wvalid <= 1'b0; w_done = 1'b1; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
  endtask : wr
  // read and compare masked data and response
  task automatic rdc(input logic [7:0] a, input logic [31:0] k, e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk({rresp, rdata & k}, {er, e});
  endtask : rdc
  // next line frame: keep what the far end sent, let outputs settle
  task automatic nf();
    @(posedge aclk iff strobe);
    fa = rx_fa; m = rx_m; f = fno;
    @(posedge aclk);
    @(negedge aclk);
  endtask : nf
  // expected slot bit of a frame, zero outside slots
  function automatic logic exp_q(input logic [4:0] x);
    logic [4:0] k;
    k = (x - 5'h01) / 5'h05;
    return ((x - 5'h01) % 5'h05 == 5'h00) ? qx[k[1:0]] : 1'b0;
  endfunction : exp_q
  task automatic give_verdict();
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // watchdog, several times the expected run
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(A_TX, 32'hFF, 32'h0, OK);
    rdc(A_CF, 32'h37, 32'h0, OK);
    rdc(8'h14, 32'hFFFFFFFF, 32'h0, SE);
    wr(8'h14, 32'h1, SE);
    // terminal mode: hunt mirrors FA, then lock, then Q in slots
    wr(A_TX, {28'h1, qx}, OK);
    repeat (10) begin nf(); chk({tx_fa, tx_m, tx_s}, {fa, 2'b00}); end
    repeat (90) nf();
    rdc(A_RX, 32'h1F, {28'h1, s_pat}, OK);
    repeat (20) begin nf(); chk({tx_fa, tx_m, tx_s}, {exp_q(f), 2'b00}); end
    // events: tick each multiframe, change flag only on new data
    wr(A_MK, 32'h3, OK);
    wr(A_ST, 32'h3, OK);
    repeat (20) nf();
    rdc(A_ST, 32'h3, 32'h1, OK);
    chk(irq, 1'b1);
    wr(A_ST, 32'h3, OK);
    s_pat <= 4'h9;
    repeat (40) nf();
    rdc(A_ST, 32'h3, 32'h3, OK);
    rdc(A_RX, 32'h1F, 32'h19, OK);
    wr(A_MK, 32'h0, OK);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    err_mf <= 1'b1;
    repeat (60) nf();
    rdc(A_RX, 32'h10, 32'h0, OK);
    err_mf <= 1'b0;
    // sync pin exports received M in terminal and line-term-T modes
    for (int md = 0; md < 4; md += 3) begin
      wr(A_CF, {26'h0, md[1:0], 4'h1}, OK);
      repeat (20) begin nf(); chk({pin_oe, pin_out}, {1'b1, m}); end
    end
    // network modes: silent until enabled, then free-running pattern
    for (int md = 1; md < 3; md++) begin
      wr(A_TX, {28'h0, qx}, OK);
      wr(A_CF, {26'h0, md[1:0], 4'h0}, OK);
      repeat (3) begin nf(); chk({tx_fa, tx_m, tx_s}, 3'h0); end
      wr(A_TX, {28'h1, qx}, OK);
      fr = 5'h00;
      repeat (45) begin
        nf();
        fr = (fr == 5'h00) ? {4'h0, tx_m} : (fr == 5'h14) ? 5'h01 : fr + 5'h01;
        if (fr != 5'h00) chk({tx_fa, tx_m, tx_s},
          {(fr - 5'h01) % 5'h05 == 5'h00, fr == 5'h01, exp_q(fr)});
      end
      chk(fr == 5'h00, 1'b0);
    end
    // sync input high holds frame 20, one low frame restarts at frame 1
    wr(A_CF, 32'h11, OK);
    pin_in <= 1'b1;
    repeat (4) begin nf(); chk({pin_oe, tx_fa, tx_m, tx_s}, 4'h0); end
    rdc(A_CF, 32'h100, 32'h100, OK);
    @(posedge aclk);
    pin_in <= 1'b0;
    nf();
    chk({tx_fa, tx_m, tx_s}, {2'b11, qx[0]});
    rdc(A_CF, 32'h100, 32'h0, OK);
    wr(A_CF, 32'h6, OK);
    @(posedge aclk);
    chk({pin_oe, pin_out}, 2'b11);
    give_verdict();
  end
endmodule : testbench
